// [adaptive_threshold_chk.sv]
// Port-level checker for the adaptive threshold control block.
`default_nettype none
module adaptive_threshold_chk (
   input wire logic       i_clk,
   input wire logic       i_resetn,
   input wire logic [7:0] i_reg_addr,
   input wire logic       i_reg_write,
   input wire logic [7:0] i_reg_wdata,
   input wire logic       i_lock,
   input wire logic       i_overtemp_pin,
   input wire logic       i_standby_supply,
   input wire logic [7:0] i_core_voltage,
   input wire logic [7:0] i_core_voltage_low_limit,
   input wire logic       i_alert_enable,
   input wire logic       i_shutdown_request,
   input wire logic [7:0] i_remote_one_temp,
   input wire logic [7:0] o_control_one,
   input wire logic [7:0] o_remote_one_op_point,
   input wire logic       o_status_bit1,
   input wire logic       o_alert,
   input wire logic       o_processor_hot_event,
   input wire logic       o_shutdown_enter
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);
   logic core_low;
   logic take;
   assign core_low = o_control_one[1] && i_standby_supply && (i_core_voltage < i_core_voltage_low_limit);
   assign take = i_reg_write && !i_lock && (i_reg_addr == 8'h36);
   sequence s_arm_r1;
      $rose(i_overtemp_pin) && o_control_one[2];
   endsequence
   sequence s_settle_r1;
      ($stable(i_remote_one_temp) && o_control_one[2] && !i_reg_write)[*5];
   endsequence
   property p_reset_zero;
      $rose(i_resetn) |-> o_control_one == 8'h00;
   endproperty
   property p_write_take;
      take |=> o_control_one == $past(i_reg_wdata);
   endproperty
   property p_write_refuse;
      !take |=> $stable(o_control_one);
   endproperty
   property p_status_set;
      core_low |=> o_status_bit1;
   endproperty
   property p_alert_on;
      core_low && i_alert_enable |=> o_alert;
   endproperty
   property p_alert_off;
      !i_alert_enable |=> !o_alert;
   endproperty
   property p_suspend;
      core_low |=> !o_shutdown_enter && !o_processor_hot_event;
   endproperty
   property p_resume;
      !core_low && i_shutdown_request |=> o_shutdown_enter;
   endproperty
   property p_capture_r1;
      s_arm_r1 ##1 s_settle_r1 |-> o_remote_one_op_point == i_remote_one_temp;
   endproperty
   property p_hold_r1;
      !o_control_one[2] && !i_reg_write |=> $stable(o_remote_one_op_point);
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("control not zero after reset");
   a_write_take: assert property (p_write_take) else $error("write not taken");
   a_write_refuse: assert property (p_write_refuse) else $error("control changed without write");
   a_status_set: assert property (p_status_set) else $error("status bit not set");
   a_alert_on: assert property (p_alert_on) else $error("alert not raised");
   a_alert_off: assert property (p_alert_off) else $error("alert while disabled");
   a_suspend: assert property (p_suspend) else $error("function not suspended");
   a_resume: assert property (p_resume) else $error("shutdown not resumed");
   a_capture_r1: assert property (p_capture_r1) else $error("remote one not captured");
   a_hold_r1: assert property (p_hold_r1) else $error("remote one point moved");
endmodule : adaptive_threshold_chk

bind adaptive_threshold_control adaptive_threshold_chk u_chk (
   .i_clk, .i_resetn, .i_reg_addr, .i_reg_write, .i_reg_wdata, .i_lock, .i_overtemp_pin,
   .i_standby_supply, .i_core_voltage, .i_core_voltage_low_limit, .i_alert_enable,
   .i_shutdown_request, .i_remote_one_temp, .o_control_one, .o_remote_one_op_point,
   .o_status_bit1, .o_alert, .o_processor_hot_event, .o_shutdown_enter
);
`default_nettype wire

// [adaptive_threshold_control.sv]
// Adaptive threshold control register, capture logic and core-voltage-low policy.
`default_nettype none
module adaptive_threshold_control (
   input  wire logic       i_clk,
   input  wire logic       i_resetn,
   input  wire logic [7:0] i_reg_addr,
   input  wire logic       i_reg_write,
   input  wire logic [7:0] i_reg_wdata,
   input  wire logic       i_lock,
   input  wire logic [1:0] i_remote_two_code_low,
   input  wire logic       i_overtemp_pin,
   input  wire logic       i_standby_supply,
   input  wire logic [7:0] i_core_voltage,
   input  wire logic [7:0] i_core_voltage_low_limit,
   input  wire logic       i_alert_enable,
   input  wire logic       i_status_bit1_clear,
   input  wire logic       i_shutdown_request,
   input  wire logic       i_processor_hot_in,
   input  wire logic       i_monitor_tick,
   input  wire logic [7:0] i_remote_one_temp,
   input  wire logic [7:0] i_local_temp,
   input  wire logic [7:0] i_remote_two_temp,
   input  wire logic [7:0] i_high_limit,
   input  wire logic [7:0] i_low_limit,
   input  wire logic [7:0] i_initial_threshold,
   input  wire logic       i_threshold_load,
   output logic      [7:0] o_control_one,
   output logic      [7:0] o_remote_one_op_point,
   output logic      [7:0] o_local_op_point,
   output logic      [7:0] o_remote_two_op_point,
   output logic      [7:0] o_remote_one_threshold,
   output logic      [7:0] o_local_threshold,
   output logic      [7:0] o_remote_two_threshold,
   output logic            o_status_bit1,
   output logic            o_alert,
   output logic            o_processor_hot_event,
   output logic            o_shutdown_enter
);
   import adaptive_threshold_pkg::*;

   logic [7:0] ctrl_reg;
   logic [7:0] ctrl_next;
   logic       ot_meta_reg;
   logic       ot_sync_reg;
   logic       ot_prev_reg;
   logic       hot_meta_reg;
   logic       hot_sync_reg;
   logic       status_reg;
   logic       status_next;
   logic       alert_reg;
   logic       alert_next;
   logic       hot_evt_reg;
   logic       hot_evt_next;
   logic       shut_reg;
   logic       shut_next;
   logic [7:0] op_r1;
   logic [7:0] op_lc;
   logic [7:0] op_r2;
   logic [7:0] thr_r1;
   logic [7:0] thr_lc;
   logic [7:0] thr_r2;
   logic       ot_rise;
   logic       core_low;
   logic [2:0] remote_two_cycle_code;
   logic [2:0] remote_one_cycle_code;
   logic [2:0] local_cycle_code;
   logic       ot_meta_next;
   logic       ot_sync_next;
   logic       ot_prev_next;
   logic       hot_meta_next;
   logic       hot_sync_next;
   logic       write_ctrl;
   logic       write_op_r1;
   logic       write_op_lc;
   logic       write_op_r2;
   logic       adapt_en_r1;
   logic       adapt_en_lc;
   logic       adapt_en_r2;

   // Address decode; the lock guards the control register and the operating points alike.
   // A locked write is dropped with no indication of any kind.
   always_comb begin
      write_ctrl  = i_reg_write && (i_reg_addr == CONTROL_ONE_OFFSET) && !i_lock;
      write_op_r1 = i_reg_write && (i_reg_addr == REMOTE_ONE_OP_OFFSET) && !i_lock;
      write_op_lc = i_reg_write && (i_reg_addr == LOCAL_OP_OFFSET) && !i_lock;
      write_op_r2 = i_reg_write && (i_reg_addr == REMOTE_TWO_OP_OFFSET) && !i_lock;
   end

   // Control register.
   always_comb begin
      ctrl_next = ctrl_reg;
      if (write_ctrl) begin
         ctrl_next = i_reg_wdata;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ctrl_reg <= CONTROL_ONE_RESET;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // The overtemperature and processor-hot pins are asynchronous, so both pass two flops.
   // Only the second flop and its delayed copy feed logic; the edge detector reads those two, never the first.
   always_comb begin
      ot_meta_next  = i_overtemp_pin;
      ot_sync_next  = ot_meta_reg;
      ot_prev_next  = ot_sync_reg;
      hot_meta_next = i_processor_hot_in;
      hot_sync_next = hot_meta_reg;
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ot_meta_reg  <= 1'b0;
         ot_sync_reg  <= 1'b0;
         ot_prev_reg  <= 1'b0;
         hot_meta_reg <= 1'b0;
         hot_sync_reg <= 1'b0;
      end else begin
         ot_meta_reg  <= ot_meta_next;
         ot_sync_reg  <= ot_sync_next;
         ot_prev_reg  <= ot_prev_next;
         hot_meta_reg <= hot_meta_next;
         hot_sync_reg <= hot_sync_next;
      end
   end

   // The edge detector rests low like the idle pin, so leaving reset makes no false capture.
   always_comb begin
      ot_rise = ot_sync_reg && !ot_prev_reg;
   end

   // Remote one and local codes live wholly in the second register, outside this block.
   always_comb begin
      remote_one_cycle_code = 3'h0;
      local_cycle_code      = 3'h0;
      remote_two_cycle_code = {ctrl_reg[CODE_MSB_BIT], i_remote_two_code_low};
   end

   // Condition is evaluated live, so everything resumes as soon as the core recovers.
   always_comb begin
      core_low = ctrl_reg[CORE_LOW_POLICY_BIT] && i_standby_supply
                 && (i_core_voltage < i_core_voltage_low_limit);
   end

   // Adaptation pauses while the core is low; its wait count restarts from zero afterwards.
   always_comb begin
      adapt_en_r1 = ctrl_reg[REMOTE_ONE_ADAPT_BIT] && !core_low;
      adapt_en_lc = ctrl_reg[LOCAL_ADAPT_BIT] && !core_low;
      adapt_en_r2 = ctrl_reg[REMOTE_TWO_ADAPT_BIT] && !core_low;
   end

   // Policy outputs; the status set wins over a same-cycle clear.
   // Alert follows the next status value, so it rises in the same cycle as the flag.
   always_comb begin
      status_next = status_reg;
      if (i_status_bit1_clear) begin
         status_next = 1'b0;
      end
      if (core_low) begin
         status_next = 1'b1;
      end
      alert_next   = status_next && i_alert_enable;
      hot_evt_next = hot_sync_reg && !core_low;
      shut_next    = i_shutdown_request && !core_low;
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         status_reg  <= 1'b0;
         alert_reg   <= 1'b0;
         hot_evt_reg <= 1'b0;
         shut_reg    <= 1'b0;
      end else begin
         status_reg  <= status_next;
         alert_reg   <= alert_next;
         hot_evt_reg <= hot_evt_next;
         shut_reg    <= shut_next;
      end
   end

   // A clear capture bit simply blocks the pin edge for that channel.
   op_point_capture u_op_r1 (
      .i_clk            (i_clk),
      .i_resetn         (i_resetn),
      .i_write          (write_op_r1),
      .i_wdata          (i_reg_wdata),
      .i_capture_enable (ctrl_reg[REMOTE_ONE_CAPTURE_BIT]),
      .i_overtemp_rise  (ot_rise),
      .i_temperature    (i_remote_one_temp),
      .o_value          (op_r1)
   );

   op_point_capture u_op_lc (
      .i_clk            (i_clk),
      .i_resetn         (i_resetn),
      .i_write          (write_op_lc),
      .i_wdata          (i_reg_wdata),
      .i_capture_enable (ctrl_reg[LOCAL_CAPTURE_BIT]),
      .i_overtemp_rise  (ot_rise),
      .i_temperature    (i_local_temp),
      .o_value          (op_lc)
   );

   op_point_capture u_op_r2 (
      .i_clk            (i_clk),
      .i_resetn         (i_resetn),
      .i_write          (write_op_r2),
      .i_wdata          (i_reg_wdata),
      .i_capture_enable (ctrl_reg[REMOTE_TWO_CAPTURE_BIT]),
      .i_overtemp_rise  (ot_rise),
      .i_temperature    (i_remote_two_temp),
      .o_value          (op_r2)
   );

   // Remote one and local use code zero here because their codes live in the second register.
   threshold_adjuster u_thr_r1 (
      .i_clk          (i_clk),
      .i_resetn       (i_resetn),
      .i_enable       (adapt_en_r1),
      .i_monitor_tick (i_monitor_tick),
      .i_cycle_code   (remote_one_cycle_code),
      .i_temperature  (i_remote_one_temp),
      .i_op_point     (op_r1),
      .i_high_limit   (i_high_limit),
      .i_low_limit    (i_low_limit),
      .i_load         (i_threshold_load),
      .i_load_value   (i_initial_threshold),
      .o_threshold    (thr_r1)
   );

   threshold_adjuster u_thr_lc (
      .i_clk          (i_clk),
      .i_resetn       (i_resetn),
      .i_enable       (adapt_en_lc),
      .i_monitor_tick (i_monitor_tick),
      .i_cycle_code   (local_cycle_code),
      .i_temperature  (i_local_temp),
      .i_op_point     (op_lc),
      .i_high_limit   (i_high_limit),
      .i_low_limit    (i_low_limit),
      .i_load         (i_threshold_load),
      .i_load_value   (i_initial_threshold),
      .o_threshold    (thr_lc)
   );

   threshold_adjuster u_thr_r2 (
      .i_clk          (i_clk),
      .i_resetn       (i_resetn),
      .i_enable       (adapt_en_r2),
      .i_monitor_tick (i_monitor_tick),
      .i_cycle_code   (remote_two_cycle_code),
      .i_temperature  (i_remote_two_temp),
      .i_op_point     (op_r2),
      .i_high_limit   (i_high_limit),
      .i_low_limit    (i_low_limit),
      .i_load         (i_threshold_load),
      .i_load_value   (i_initial_threshold),
      .o_threshold    (thr_r2)
   );

   // Every output comes straight from a register.
   assign o_control_one          = ctrl_reg;
   assign o_remote_one_op_point  = op_r1;
   assign o_local_op_point       = op_lc;
   assign o_remote_two_op_point  = op_r2;
   assign o_remote_one_threshold = thr_r1;
   assign o_local_threshold      = thr_lc;
   assign o_remote_two_threshold = thr_r2;
   assign o_status_bit1          = status_reg;
   assign o_alert                = alert_reg;
   assign o_processor_hot_event  = hot_evt_reg;
   assign o_shutdown_enter       = shut_reg;
endmodule : adaptive_threshold_control
`default_nettype wire

// [adaptive_threshold_pkg.sv]
// Package of register offsets, field positions, reset values and timing counts for the adaptive threshold block.
`default_nettype none
package adaptive_threshold_pkg;
   localparam logic [7:0] CONTROL_ONE_OFFSET     = 8'h36;
   localparam logic [7:0] CONTROL_TWO_OFFSET     = 8'h37;
   localparam logic [7:0] REMOTE_ONE_OP_OFFSET   = 8'h33;
   localparam logic [7:0] LOCAL_OP_OFFSET        = 8'h34;
   localparam logic [7:0] REMOTE_TWO_OP_OFFSET   = 8'h35;
   localparam logic [7:0] CONTROL_ONE_RESET      = 8'h00;
   localparam logic [7:0] OP_POINT_RESET         = 8'h64;
   localparam int         CODE_MSB_BIT           = 0;
   localparam int         CORE_LOW_POLICY_BIT    = 1;
   localparam int         REMOTE_ONE_CAPTURE_BIT = 2;
   localparam int         LOCAL_CAPTURE_BIT      = 3;
   localparam int         REMOTE_TWO_CAPTURE_BIT = 4;
   localparam int         REMOTE_ONE_ADAPT_BIT   = 5;
   localparam int         LOCAL_ADAPT_BIT        = 6;
   localparam int         REMOTE_TWO_ADAPT_BIT   = 7;
   localparam int         CODE_LOW_POS           = 6;
   localparam logic [11:0] BASE_DECREASE_CYCLES  = 12'h008;
   localparam logic [11:0] BASE_INCREASE_CYCLES  = 12'h010;
   localparam logic [7:0] THRESHOLD_STEP         = 8'h01;
endpackage : adaptive_threshold_pkg
`default_nettype wire

// [op_point_capture.sv]
// One operating-point register with host write and overtemperature capture.
`default_nettype none
module op_point_capture (
   input  wire logic       i_clk,
   input  wire logic       i_resetn,
   input  wire logic       i_write,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_capture_enable,
   input  wire logic       i_overtemp_rise,
   input  wire logic [7:0] i_temperature,
   output logic      [7:0] o_value
);
   import adaptive_threshold_pkg::*;
   logic [7:0] value_reg;
   logic [7:0] value_next;

   // Capture beats a same-cycle host write so an alarm point is never lost.
   always_comb begin
      value_next = value_reg;
      if (i_write) begin
         value_next = i_wdata;
      end
      if (i_capture_enable && i_overtemp_rise) begin
         value_next = i_temperature;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         value_reg <= OP_POINT_RESET;
      end else begin
         value_reg <= value_next;
      end
   end

   assign o_value = value_reg;
endmodule : op_point_capture
`default_nettype wire

// [reg_host.sv]
// Register host model issuing single-byte writes.
`default_nettype none
module reg_host (
   input  wire logic       i_clk,
   output var  logic [7:0] o_addr,
   output var  logic       o_write,
   output var  logic [7:0] o_wdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      o_addr = 8'h00;
      o_write = 1'b0;
      o_wdata = 8'h00;
   end
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      @(posedge i_clk);
      o_addr  <= addr;
      o_wdata <= data;
      o_write <= 1'b1;
      @(posedge i_clk);
      o_write <= 1'b0;
      // Released lines show the inverse so a stale byte cannot pass for a live one.
      o_addr  <= ~addr;
      o_wdata <= ~data;
   endtask : write_reg
endmodule : reg_host
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the adaptive threshold control block.
`default_nettype none
module tb_top;
   import adaptive_threshold_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic       i_clk = 1'b0, i_resetn = 1'b0, i_reg_write, i_lock, i_overtemp_pin, i_standby_supply;
   logic       i_alert_enable, i_status_bit1_clear, i_shutdown_request, i_processor_hot_in;
   logic       i_monitor_tick, i_threshold_load, o_status_bit1, o_alert, o_processor_hot_event, o_shutdown_enter;
   logic [1:0] i_remote_two_code_low;
   logic [7:0] i_reg_addr, i_reg_wdata, i_core_voltage, i_core_voltage_low_limit, i_remote_one_temp;
   logic [7:0] i_local_temp, i_remote_two_temp, i_high_limit, i_low_limit, i_initial_threshold;
   logic [7:0] o_control_one, o_remote_one_op_point, o_local_op_point, o_remote_two_op_point;
   logic [7:0] o_remote_one_threshold, o_local_threshold, o_remote_two_threshold;
   logic [7:0] exp_op [3];
   int         bad_count = 0, check_count = 0, cycles = 0;
   reg_host u_host (.i_clk, .o_addr(i_reg_addr), .o_write(i_reg_write), .o_wdata(i_reg_wdata));
   adaptive_threshold_control u_dut (
      .i_clk, .i_resetn, .i_reg_addr, .i_reg_write, .i_reg_wdata, .i_lock, .i_remote_two_code_low,
      .i_overtemp_pin, .i_standby_supply, .i_core_voltage, .i_core_voltage_low_limit, .i_alert_enable,
      .i_status_bit1_clear, .i_shutdown_request, .i_processor_hot_in, .i_monitor_tick, .i_remote_one_temp,
      .i_local_temp, .i_remote_two_temp, .i_high_limit, .i_low_limit, .i_initial_threshold,
      .i_threshold_load, .o_control_one, .o_remote_one_op_point, .o_local_op_point, .o_remote_two_op_point,
      .o_remote_one_threshold, .o_local_threshold, .o_remote_two_threshold, .o_status_bit1, .o_alert,
      .o_processor_hot_event, .o_shutdown_enter);
   always #25 i_clk = ~i_clk;
   task automatic complete_run;
      $display("Checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : complete_run
   // The ceiling is several times the roughly 500 cycles that the whole run takes.
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 4000) begin
         bad_count++;
         complete_run();
      end
   end
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge i_clk);
         i_monitor_tick <= 1'b1;
         @(posedge i_clk);
         i_monitor_tick <= 1'b0;
      end
      repeat (2) @(posedge i_clk);
      @(negedge i_clk);
   endtask : ticks
   task automatic settle(input int n);
      repeat (n) @(posedge i_clk);
      @(negedge i_clk);
   endtask : settle
   initial begin
      {i_lock, i_overtemp_pin, i_standby_supply, i_alert_enable, i_status_bit1_clear} = '0;
      {i_shutdown_request, i_processor_hot_in, i_monitor_tick, i_threshold_load} = '0;
      i_remote_two_code_low = 2'h0;
      {i_core_voltage, i_core_voltage_low_limit, i_high_limit, i_low_limit} = {8'h80, 8'h20, 8'h80, 8'h20};
      {i_remote_one_temp, i_local_temp, i_remote_two_temp, i_initial_threshold} = {8'h40, 8'h40, 8'h40, 8'h30};
      exp_op = '{OP_POINT_RESET, OP_POINT_RESET, OP_POINT_RESET};
      repeat (20) @(posedge i_clk);
      i_resetn <= 1'b1;
      settle(1);
      check("control_one", o_control_one, CONTROL_ONE_RESET);
      check("r1_op", o_remote_one_op_point, OP_POINT_RESET);
      $display("Test reset done");
      u_host.write_reg(CONTROL_ONE_OFFSET, 8'hA5);
      settle(0);
      check("control_one", o_control_one, 8'hA5);
      @(posedge i_clk);
      i_lock <= 1'b1;
      u_host.write_reg(CONTROL_ONE_OFFSET, 8'h5A);
      u_host.write_reg(REMOTE_ONE_OP_OFFSET, 8'h11);
      settle(0);
      check("control_one", o_control_one, 8'hA5);
      check("r1_op", o_remote_one_op_point, OP_POINT_RESET);
      @(posedge i_clk);
      i_lock <= 1'b0;
      u_host.write_reg(CONTROL_TWO_OFFSET, 8'hFF);
      settle(0);
      check("control_one", o_control_one, 8'hA5);
      $display("Test writes done");
      for (int i = 0; i < 3; i++) begin
         u_host.write_reg(CONTROL_ONE_OFFSET, 8'(8'h04 << i));
         @(posedge i_clk);
         {i_remote_one_temp, i_local_temp, i_remote_two_temp} <= {8'(8'h50 + i), 8'(8'h60 + i), 8'(8'h70 + i)};
         i_overtemp_pin <= 1'b1;
         repeat (8) @(posedge i_clk);
         i_overtemp_pin <= 1'b0;
         settle(8);
         exp_op[i] = 8'(8'h50 + 8'h10 * i + i);
         check("r1_op", o_remote_one_op_point, exp_op[0]);
         check("local_op", o_local_op_point, exp_op[1]);
         check("r2_op", o_remote_two_op_point, exp_op[2]);
      end
      $display("Test capture done");
      u_host.write_reg(CONTROL_ONE_OFFSET, 8'h02);
      @(posedge i_clk);
      {i_core_voltage, i_shutdown_request, i_processor_hot_in, i_alert_enable} <= {8'h10, 3'b111};
      settle(4);
      check("status", o_status_bit1, 8'h00);
      check("shutdown", o_shutdown_enter, 8'h01);
      @(posedge i_clk);
      i_standby_supply <= 1'b1;
      settle(3);
      check("status", o_status_bit1, 8'h01);
      check("alert", o_alert, 8'h01);
      check("shutdown", o_shutdown_enter, 8'h00);
      check("hot_event", o_processor_hot_event, 8'h00);
      @(posedge i_clk);
      {i_alert_enable, i_status_bit1_clear} <= 2'b01;
      @(posedge i_clk);
      i_status_bit1_clear <= 1'b0;
      settle(2);
      check("alert", o_alert, 8'h00);
      check("status", o_status_bit1, 8'h01);
      @(posedge i_clk);
      i_core_voltage <= 8'h30;
      settle(4);
      check("shutdown", o_shutdown_enter, 8'h01);
      check("hot_event", o_processor_hot_event, 8'h01);
      $display("Test core low done");
      @(posedge i_clk);
      {i_standby_supply, i_shutdown_request, i_threshold_load} <= 3'b001;
      {i_remote_one_temp, i_local_temp, i_remote_two_temp} <= {8'h90, 8'h90, 8'h90};
      @(posedge i_clk);
      i_threshold_load <= 1'b0;
      u_host.write_reg(CONTROL_ONE_OFFSET, 8'hA1);
      ticks(7);
      check("r1_th", o_remote_one_threshold, 8'h30);
      ticks(1);
      check("r1_th", o_remote_one_threshold, 8'h2F);
      check("local_th", o_local_threshold, 8'h30);
      ticks(119);
      check("r2_th", o_remote_two_threshold, 8'h30);
      ticks(1);
      check("r2_th", o_remote_two_threshold, 8'h2F);
      check("r1_th", o_remote_one_threshold, 8'h20);
      u_host.write_reg(CONTROL_ONE_OFFSET, 8'h00);
      @(posedge i_clk);
      i_remote_one_temp <= 8'h10;
      u_host.write_reg(CONTROL_ONE_OFFSET, 8'h20);
      ticks(15);
      check("r1_th", o_remote_one_threshold, 8'h20);
      ticks(1);
      check("r1_th", o_remote_one_threshold, 8'h21);
      u_host.write_reg(CONTROL_ONE_OFFSET, 8'h22);
      @(posedge i_clk);
      {i_standby_supply, i_core_voltage} <= {1'b1, 8'h10};
      ticks(16);
      check("r1_th", o_remote_one_threshold, 8'h21);
      @(posedge i_clk);
      i_core_voltage <= 8'h30;
      ticks(16);
      check("r1_th", o_remote_one_threshold, 8'h22);
      $display("Test adaptation done");
      @(posedge i_clk);
      i_resetn <= 1'b0;
      settle(2);
      check("control_one", o_control_one, CONTROL_ONE_RESET);
      check("r1_op", o_remote_one_op_point, OP_POINT_RESET);
      @(posedge i_clk);
      i_resetn <= 1'b1;
      settle(2);
      check("control_one", o_control_one, CONTROL_ONE_RESET);
      $display("Test reset again done");
      complete_run();
   end
endmodule : tb_top
`default_nettype wire

// [threshold_adjuster.sv]
// Adaptive fan-start threshold adjuster for one temperature channel.
`default_nettype none
module threshold_adjuster (
   input  wire logic       i_clk,
   input  wire logic       i_resetn,
   input  wire logic       i_enable,
   input  wire logic       i_monitor_tick,
   input  wire logic [2:0] i_cycle_code,
   input  wire logic [7:0] i_temperature,
   input  wire logic [7:0] i_op_point,
   input  wire logic [7:0] i_high_limit,
   input  wire logic [7:0] i_low_limit,
   input  wire logic       i_load,
   input  wire logic [7:0] i_load_value,
   output logic      [7:0] o_threshold
);
   import adaptive_threshold_pkg::*;
   logic [7:0]  thr_reg;
   logic [7:0]  thr_next;
   logic [11:0] cnt_reg;
   logic [11:0] cnt_next;
   logic [11:0] dec_limit;
   logic [11:0] inc_limit;
   logic        want_dec;
   logic        want_inc;

   // Each code step doubles both waits.
   always_comb begin
      dec_limit = BASE_DECREASE_CYCLES << i_cycle_code;
      inc_limit = BASE_INCREASE_CYCLES << i_cycle_code;
      want_dec  = (i_temperature > i_op_point) || (i_temperature > i_high_limit);
      want_inc  = (i_temperature < i_op_point) && (i_temperature < i_low_limit);
      thr_next  = thr_reg;
      cnt_next  = cnt_reg;
      if (i_load) begin
         thr_next = i_load_value;
         cnt_next = 12'h000;
      end else if (!i_enable) begin
         cnt_next = 12'h000;
      end else if (i_monitor_tick) begin
         cnt_next = cnt_reg + 12'h001;
         if (want_dec && (cnt_next >= dec_limit)) begin
            if (thr_reg != 8'h00) begin
               thr_next = thr_reg - THRESHOLD_STEP;
            end
            cnt_next = 12'h000;
         end else if (want_inc && (cnt_next >= inc_limit)) begin
            if (thr_reg < i_op_point) begin
               thr_next = thr_reg + THRESHOLD_STEP;
            end
            cnt_next = 12'h000;
         end else if (!want_dec && !want_inc) begin
            cnt_next = 12'h000;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         thr_reg <= 8'h00;
         cnt_reg <= 12'h000;
      end else begin
         thr_reg <= thr_next;
         cnt_reg <= cnt_next;
      end
   end

   assign o_threshold = thr_reg;
endmodule : threshold_adjuster
`default_nettype wire
